/* rtl/lsa_params.svh */
/*
 Constants for the load/store lane alignment unit: option codes, lane masks,
 special register number and reset values. Assumes inclusion by bare name.
*/
`ifndef LSA_PARAMS_SVH
`define LSA_PARAMS_SVH
`define LSA_OPT_WORD       3'h0
`define LSA_OPT_BYTE       3'h1
`define LSA_OPT_HALF       3'h2
`define LSA_SPR_XFER_COUNT 8'h87
`define LSA_BP_SIGN_SET    2'h3
`define LSA_BP_RESET       2'h0
`define LSA_XCNT_RESET     8'h00
`define LSA_LANES_NONE     4'h0
`define LSA_LANES_ALL      4'hf
`define LSA_LANES_HI_HALF  4'hc
`define LSA_LANES_LO_HALF  4'h3
`define LSA_LANE_TOP_BYTE  4'h8
`define LSA_LOW_ZERO       2'h0
`define LSA_PC_RESET       30'h00000000
`endif

/* rtl/lsa_pkg.sv */
/*
 Types shared by the load/store lane alignment unit.
 Assumes the constants header is compiled alongside.
*/
package lsa_pkg;
	typedef logic [31:0] lsa_word_t;
	typedef logic [2:0]  lsa_opt_t;
	typedef logic [3:0]  lsa_lanes_t;
	typedef logic [1:0]  lsa_bp_t;
endpackage

/* rtl/lsa_align_unit.sv */
/*
 Load/store lane selection, alignment check, transfer count register and
 instruction address generation. One access is taken per cycle and answered
 one cycle later. Assumes the core presents the loaded word with the access.
*/
`include "lsa_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lsa_align_unit
	import lsa_pkg::*;
#(
	parameter int COUNT_W = 8
) (
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	input  wire logic              acc_valid_i,
	input  wire logic              acc_store_i,
	input  wire lsa_pkg::lsa_opt_t access_option_field_i,
	input  wire logic              sign_extend_bit_i,
	input  wire lsa_pkg::lsa_word_t acc_addr_i,
	input  wire lsa_pkg::lsa_word_t load_word_i,
	input  wire lsa_pkg::lsa_word_t store_src_i,
	input  wire logic              trap_misaligned_enable_i,
	input  wire logic              spr_wr_i,
	input  wire logic              spr_rd_i,
	input  wire logic [7:0]        spr_num_i,
	input  wire lsa_pkg::lsa_word_t spr_wdata_i,
	input  wire logic              ccr_count_wr_i,
	input  wire logic [COUNT_W-1:0] ccr_count_i,
	input  wire logic              xfer_done_i,
	input  wire logic              bp_wr_i,
	input  wire lsa_pkg::lsa_bp_t  bp_wdata_i,
	input  wire logic              pc_step_i,
	input  wire logic              pc_jump_i,
	input  wire lsa_pkg::lsa_word_t pc_target_i,
	output logic                   done_o,
	output lsa_pkg::lsa_word_t     load_result_o,
	output lsa_pkg::lsa_word_t     store_data_o,
	output lsa_pkg::lsa_lanes_t    lane_we_o,
	output lsa_pkg::lsa_word_t     mem_addr_o,
	output logic                   trap_misaligned_o,
	output lsa_pkg::lsa_bp_t       byte_pointer_field_o,
	output logic [COUNT_W-1:0]     multiple_transfer_count_o,
	output logic [COUNT_W:0]       transfer_total_o,
	output lsa_pkg::lsa_word_t     spr_rdata_o,
	output logic                   spr_rvalid_o,
	output lsa_pkg::lsa_word_t     instr_addr_o
);
	import lsa_pkg::*;

	generate
		if (COUNT_W < 1 || COUNT_W > 31) begin : g_bad_width
			$error("COUNT_W must lie in 1..31");
		end
	endgenerate

	// Big-endian lane of a byte: offset 0 is bits 31:24
	function automatic logic [7:0] pick_byte(input lsa_word_t w, input logic [1:0] a);
		pick_byte = w[8*(3-a) +: 8];
	endfunction

	function automatic logic [15:0] pick_half(input lsa_word_t w, input logic a1);
		pick_half = a1 ? w[15:0] : w[31:16];
	endfunction

	// Access path
	lsa_word_t  next_load_result, next_store_data, next_mem_addr;
	lsa_lanes_t next_lane_we;
	logic       next_done, next_trap;
	logic [7:0] sel_b;
	logic [15:0] sel_h;
	logic       misaligned;

	always_comb begin
		sel_b = pick_byte(load_word_i, acc_addr_i[1:0]);
		sel_h = pick_half(load_word_i, acc_addr_i[1]);
		misaligned = 1'b0;
		if (access_option_field_i == `LSA_OPT_WORD) begin
			misaligned = acc_addr_i[1:0] != `LSA_LOW_ZERO;
		end else if (access_option_field_i == `LSA_OPT_HALF) begin
			misaligned = acc_addr_i[0];
		end
		next_done = acc_valid_i;
		next_trap = acc_valid_i && trap_misaligned_enable_i && misaligned;
		next_load_result = load_result_o;
		next_store_data = store_data_o;
		next_mem_addr = mem_addr_o;
		next_lane_we = `LSA_LANES_NONE;
		if (acc_valid_i) begin
			case (access_option_field_i)
				`LSA_OPT_BYTE: begin
					next_load_result = {{24{sign_extend_bit_i & sel_b[7]}}, sel_b};
					next_store_data = {4{store_src_i[7:0]}};
					next_lane_we = `LSA_LANE_TOP_BYTE >> acc_addr_i[1:0];
					next_mem_addr = acc_addr_i;
				end
				`LSA_OPT_HALF: begin
					next_load_result = {{16{sign_extend_bit_i & sel_h[15]}}, sel_h};
					next_store_data = {2{store_src_i[15:0]}};
					next_lane_we = acc_addr_i[1] ? `LSA_LANES_LO_HALF : `LSA_LANES_HI_HALF;
					next_mem_addr = {acc_addr_i[31:1], 1'b0};
				end
				default: begin
					next_load_result = load_word_i;
					next_store_data = store_src_i;
					next_lane_we = `LSA_LANES_ALL;
					next_mem_addr = {acc_addr_i[31:2], `LSA_LOW_ZERO};
				end
			endcase
			// A trapped access and a load write no lanes
			if (next_trap || !acc_store_i) begin
				next_lane_we = `LSA_LANES_NONE;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
			trap_misaligned_o <= 1'b0;
			load_result_o <= '0;
			store_data_o <= '0;
			mem_addr_o <= '0;
			lane_we_o <= `LSA_LANES_NONE;
		end else begin
			done_o <= next_done;
			trap_misaligned_o <= next_trap;
			load_result_o <= next_load_result;
			store_data_o <= next_store_data;
			mem_addr_o <= next_mem_addr;
			lane_we_o <= next_lane_we;
		end
	end

	// Byte pointer field
	lsa_bp_t next_bp;
	always_comb begin
		next_bp = byte_pointer_field_o;
		if (bp_wr_i) begin
			next_bp = bp_wdata_i;
		end
		// A sign-extending access wins over a software write in the same cycle
		if (acc_valid_i && sign_extend_bit_i) begin
			next_bp = `LSA_BP_SIGN_SET;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			byte_pointer_field_o <= `LSA_BP_RESET;
		end else begin
			byte_pointer_field_o <= next_bp;
		end
	end

	// Transfer count: one field, two ways in
	logic [COUNT_W-1:0] next_count;
	logic [COUNT_W:0]   next_total;
	lsa_word_t          next_rdata;
	logic               next_rvalid, spr_hit;
	always_comb begin
		spr_hit = spr_num_i == `LSA_SPR_XFER_COUNT;
		next_count = multiple_transfer_count_o;
		if (xfer_done_i && multiple_transfer_count_o != '0) begin
			next_count = multiple_transfer_count_o - 1'b1;
		end
		// Software writes win over the hardware countdown
		if (ccr_count_wr_i) begin
			next_count = ccr_count_i;
		end
		if (spr_wr_i && spr_hit) begin
			next_count = spr_wdata_i[COUNT_W-1:0];
		end
		next_total = {1'b0, next_count} + 1'b1;
		next_rvalid = spr_rd_i && spr_hit;
		next_rdata = '0;
		if (next_rvalid) begin
			next_rdata[COUNT_W-1:0] = multiple_transfer_count_o;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			multiple_transfer_count_o <= COUNT_W'(`LSA_XCNT_RESET);
			transfer_total_o <= '0;
			spr_rdata_o <= '0;
			spr_rvalid_o <= 1'b0;
		end else begin
			multiple_transfer_count_o <= next_count;
			transfer_total_o <= next_total;
			spr_rdata_o <= next_rdata;
			spr_rvalid_o <= next_rvalid;
		end
	end

	// Program counter: low two bits are never stored, so they cannot leak
	logic [29:0] pc, next_pc;
	always_comb begin
		next_pc = pc;
		if (pc_jump_i) begin
			next_pc = pc_target_i[31:2];
		end else if (pc_step_i) begin
			next_pc = pc + 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pc <= `LSA_PC_RESET;
			instr_addr_o <= '0;
		end else begin
			pc <= next_pc;
			instr_addr_o <= {next_pc, `LSA_LOW_ZERO};
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	property p_spr_write;
		spr_wr_i && spr_hit |=> multiple_transfer_count_o == $past(spr_wdata_i[COUNT_W-1:0]);
	endproperty
	a_spr_write: assert property (p_spr_write) else $error("count not written");

	property p_byte_zero;
		acc_valid_i && access_option_field_i == `LSA_OPT_BYTE && !sign_extend_bit_i
			&& acc_addr_i[1:0] == 2'h0
			|=> load_result_o == {24'h0, $past(load_word_i[31:24])};
	endproperty
	a_byte_zero: assert property (p_byte_zero) else $error("byte 00 not top lane");

	property p_half_sel;
		acc_valid_i && access_option_field_i == `LSA_OPT_HALF && !sign_extend_bit_i
			|=> load_result_o[15:0] == ($past(acc_addr_i[1]) ? $past(load_word_i[15:0])
				: $past(load_word_i[31:16]));
	endproperty
	a_half_sel: assert property (p_half_sel) else $error("half select wrong");

	property p_sign_fill;
		acc_valid_i && access_option_field_i == `LSA_OPT_BYTE && sign_extend_bit_i
			|=> load_result_o[31:8] == {24{load_result_o[7]}};
	endproperty
	a_sign_fill: assert property (p_sign_fill) else $error("sign fill wrong");

	property p_store_rep;
		acc_valid_i && acc_store_i && access_option_field_i == `LSA_OPT_BYTE
			|=> store_data_o == {4{$past(store_src_i[7:0])}};
	endproperty
	a_store_rep: assert property (p_store_rep) else $error("store byte not copied");

	property p_lane_count;
		acc_valid_i && acc_store_i && access_option_field_i == `LSA_OPT_BYTE
			|=> lane_we_o == (4'h1 << (2'h3 - $past(acc_addr_i[1:0])));
	endproperty
	a_lane_count: assert property (p_lane_count) else $error("bad lane mask");

	property p_bp_set;
		acc_valid_i && sign_extend_bit_i |=> byte_pointer_field_o == 2'h3;
	endproperty
	a_bp_set: assert property (p_bp_set) else $error("pointer not set");

	property p_trap;
		acc_valid_i |=> trap_misaligned_o == ($past(trap_misaligned_enable_i) && $past(misaligned));
	endproperty
	a_trap: assert property (p_trap) else $error("trap mismatch");

	property p_word_trap;
		acc_valid_i && trap_misaligned_enable_i && access_option_field_i == `LSA_OPT_WORD
			&& acc_addr_i[1:0] != 2'h0 |=> trap_misaligned_o && lane_we_o == 4'h0;
	endproperty
	a_word_trap: assert property (p_word_trap) else $error("word trap missed");

	property p_iaddr;
		pc_jump_i |=> instr_addr_o == {$past(pc_target_i[31:2]), 2'h0};
	endproperty
	a_iaddr: assert property (p_iaddr) else $error("instruction address unaligned");

	property p_total;
		!$past(rst_i) |-> transfer_total_o == {1'b0, multiple_transfer_count_o} + 1'b1;
	endproperty
	a_total: assert property (p_total) else $error("total not count plus one");

	property p_noalign;
		acc_valid_i && !trap_misaligned_enable_i && access_option_field_i == `LSA_OPT_WORD
			|=> mem_addr_o[1:0] == 2'h0 && !trap_misaligned_o;
	endproperty
	a_noalign: assert property (p_noalign) else $error("word not forced aligned");
endmodule
`default_nettype wire

/* test/lsa_mem_model.sv */
/*
 Memory behind the lane unit: four words, lanes written one edge after they show.
 Assumes the unit's address, lane and data outputs drive it directly.
*/
`timescale 1ns/1ps
`default_nettype none
module lsa_mem_model (
	input  wire logic        mclk_i,
	input  wire logic [31:0] rd_addr_i,
	input  wire logic [31:0] wr_addr_i,
	input  wire logic [3:0]  wr_lanes_i,
	input  wire logic [31:0] wr_data_i,
	output logic      [31:0] rd_word_o
);
	logic [31:0] mem [4];
	initial begin
		for (int i = 0; i < 4; i++) begin
			mem[i] = 32'h8172f3e4;
		end
	end
	// Whole words only: the two low address bits are read as zero
	assign rd_word_o = mem[rd_addr_i[3:2]];
	always @(posedge mclk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (wr_lanes_i[i]) begin
				mem[wr_addr_i[3:2]][8*i +: 8] <= wr_data_i[8*i +: 8];
			end
		end
	end
endmodule
`default_nettype wire

/* test/lsa_align_unit_test.sv */
/*
 Self-checking bench for the lane alignment unit.
 Assumes the unit and the four-word memory model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module lsa_align_unit_test;
	import lsa_pkg::*;
	logic mclk_i = 1'b0, rst_i = 1'b1, acc_valid_i = 1'b0, acc_store_i = 1'b0;
	logic sign_extend_bit_i = 1'b0, trap_misaligned_enable_i = 1'b0, spr_wr_i = 1'b0;
	logic spr_rd_i = 1'b0, ccr_count_wr_i = 1'b0, xfer_done_i = 1'b0, bp_wr_i = 1'b0;
	logic pc_step_i = 1'b0, pc_jump_i = 1'b0, done_o, trap_misaligned_o, spr_rvalid_o;
	lsa_opt_t access_option_field_i = 3'h0;
	lsa_bp_t bp_wdata_i = 2'h0, byte_pointer_field_o;
	lsa_lanes_t lane_we_o;
	logic [7:0] spr_num_i = 8'h00, ccr_count_i = 8'h00, multiple_transfer_count_o;
	logic [8:0] transfer_total_o;
	lsa_word_t acc_addr_i = 32'h0, store_src_i = 32'h0, spr_wdata_i = 32'h0;
	lsa_word_t pc_target_i = 32'h0, load_word_i, load_result_o, store_data_o;
	lsa_word_t mem_addr_o, spr_rdata_o, instr_addr_o;
	int err_count = 0;
	int cmp_count = 0;
	lsa_align_unit #(.COUNT_W(8)) lsa_align_unit_inst (.mclk_i, .rst_i, .acc_valid_i,
		.acc_store_i, .access_option_field_i, .sign_extend_bit_i, .acc_addr_i, .load_word_i,
		.store_src_i, .trap_misaligned_enable_i, .spr_wr_i, .spr_rd_i, .spr_num_i, .spr_wdata_i,
		.ccr_count_wr_i, .ccr_count_i, .xfer_done_i, .bp_wr_i, .bp_wdata_i, .pc_step_i,
		.pc_jump_i, .pc_target_i, .done_o, .load_result_o, .store_data_o, .lane_we_o,
		.mem_addr_o, .trap_misaligned_o, .byte_pointer_field_o, .multiple_transfer_count_o,
		.transfer_total_o, .spr_rdata_o, .spr_rvalid_o, .instr_addr_o);
	lsa_mem_model lsa_mem_model_inst (.mclk_i, .rd_addr_i(acc_addr_i), .wr_addr_i(mem_addr_o),
		.wr_lanes_i(lane_we_o), .wr_data_i(store_data_o), .rd_word_o(load_word_i));
	always #2.5 mclk_i = ~mclk_i;
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One access, then wait a bounded time for its answer
	task automatic acc(logic s, lsa_opt_t o, logic b, lsa_word_t a, lsa_word_t d);
		int n;
		n = 0;
		@(posedge mclk_i);
		acc_valid_i <= 1'b1;
		acc_store_i <= s;
		access_option_field_i <= o;
		sign_extend_bit_i <= b;
		acc_addr_i <= a;
		store_src_i <= d;
		@(posedge mclk_i);
		acc_valid_i <= 1'b0;
		#1;
		while (done_o !== 1'b1) begin
			n++;
			if (n > 4) begin
				chk("done_o", 32'(done_o), 32'h1);
				wrap_up();
			end
			@(posedge mclk_i);
			#1;
		end
	endtask
	task automatic reg_op(logic w, logic r, logic [7:0] n, lsa_word_t d);
		@(posedge mclk_i);
		spr_wr_i <= w;
		spr_rd_i <= r;
		spr_num_i <= n;
		spr_wdata_i <= d;
		@(posedge mclk_i);
		spr_wr_i <= 1'b0;
		spr_rd_i <= 1'b0;
		#1;
	endtask
	task automatic t_load;
		lsa_word_t w;
		logic [7:0] b;
		logic [15:0] h;
		w = 32'h8172f3e4;
		for (int a = 0; a < 8; a++) begin
			b = w[31 - 8 * (a % 4) -: 8];
			h = a[1] ? w[15:0] : w[31:16];
			acc(1'b0, 3'h1, a[2], 32'(a), 32'h0);
			chk("byte load", load_result_o, a[2] ? {{24{b[7]}}, b} : {24'h0, b});
			acc(1'b0, 3'h2, a[2], 32'(a), 32'h0);
			chk("half load", load_result_o, a[2] ? {{16{h[15]}}, h} : {16'h0, h});
		end
	endtask
	task automatic t_store;
		for (int a = 0; a < 4; a++) begin
			acc(1'b1, 3'h1, 1'b0, 32'h10 + 32'(a), 32'h123456a5);
			chk("byte data", store_data_o, 32'ha5a5a5a5);
			chk("byte lanes", 32'(lane_we_o), 32'(4'h8 >> a));
			acc(1'b1, 3'h2, 1'b0, 32'h18 + 32'(a), 32'h1234c3d2);
			chk("half data", store_data_o, 32'hc3d2c3d2);
			chk("half lanes", 32'(lane_we_o), a[1] ? 32'h3 : 32'hc);
			chk("half addr", mem_addr_o, 32'h18 + 32'(a & 2));
		end
		// Only the addressed byte of an untouched word may change
		acc(1'b1, 3'h1, 1'b0, 32'h26, 32'h5a);
		acc(1'b0, 3'h0, 1'b0, 32'h24, 32'h0);
		chk("merged word", load_result_o, 32'h81725ae4);
	endtask
	task automatic t_bp;
		@(posedge mclk_i);
		bp_wr_i <= 1'b1;
		bp_wdata_i <= 2'h1;
		@(posedge mclk_i);
		bp_wr_i <= 1'b0;
		acc(1'b1, 3'h0, 1'b0, 32'h0, 32'h0);
		chk("pointer kept", 32'(byte_pointer_field_o), 32'h1);
		acc(1'b1, 3'h0, 1'b1, 32'h4, 32'h77);
		chk("pointer set", 32'(byte_pointer_field_o), 32'h3);
		chk("signed store", store_data_o, 32'h77);
	endtask
	task automatic t_trap;
		lsa_opt_t o;
		logic t;
		@(posedge mclk_i);
		trap_misaligned_enable_i <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			o = (i < 4) ? 3'h0 : ((i < 8) ? 3'h2 : 3'h1);
			t = (i < 4) ? (i != 0) : ((i < 8) ? i[0] : 1'b0);
			acc(1'b1, o, 1'b0, 32'h30 + 32'(i % 4), 32'h0);
			chk("trap", 32'(trap_misaligned_o), 32'(t));
			if (t)
				chk("trapped lanes", 32'(lane_we_o), 32'h0);
		end
		// Codes outside word, byte and half never raise the trap
		acc(1'b1, 3'h4, 1'b0, 32'h31, 32'h0);
		chk("other code trap", 32'(trap_misaligned_o), 32'h0);
		@(posedge mclk_i);
		trap_misaligned_enable_i <= 1'b0;
		for (int i = 1; i < 4; i++) begin
			acc(1'b1, 3'h0, 1'b0, 32'h30 + 32'(i), 32'h0);
			chk("no trap", 32'(trap_misaligned_o), 32'h0);
			chk("aligned addr", mem_addr_o, 32'h30);
			chk("word lanes", 32'(lane_we_o), 32'hf);
		end
	endtask
	task automatic t_spr;
		reg_op(1'b1, 1'b0, 8'h87, 32'hffffff05);
		chk("count", 32'(multiple_transfer_count_o), 32'h5);
		chk("total", 32'(transfer_total_o), 32'h6);
		reg_op(1'b0, 1'b1, 8'h87, 32'h0);
		chk("read valid", 32'(spr_rvalid_o), 32'h1);
		chk("read data", spr_rdata_o, 32'h5);
		reg_op(1'b1, 1'b0, 8'h86, 32'h9);
		chk("other number", 32'(multiple_transfer_count_o), 32'h5);
		reg_op(1'b0, 1'b1, 8'h86, 32'h0);
		chk("no read valid", 32'(spr_rvalid_o), 32'h0);
		@(posedge mclk_i);
		ccr_count_wr_i <= 1'b1;
		ccr_count_i <= 8'hff;
		@(posedge mclk_i);
		ccr_count_wr_i <= 1'b0;
		xfer_done_i <= 1'b1;
		#1;
		chk("total max", 32'(transfer_total_o), 32'h100);
		@(posedge mclk_i);
		xfer_done_i <= 1'b0;
		reg_op(1'b0, 1'b1, 8'h87, 32'h0);
		chk("alias read", spr_rdata_o, 32'hfe);
	endtask
	task automatic t_pc;
		@(posedge mclk_i);
		pc_jump_i <= 1'b1;
		pc_target_i <= 32'h00001013;
		@(posedge mclk_i);
		pc_jump_i <= 1'b0;
		pc_step_i <= 1'b1;
		#1;
		chk("jump", instr_addr_o, 32'h1010);
		@(posedge mclk_i);
		pc_step_i <= 1'b0;
		#1;
		chk("step", instr_addr_o, 32'h1014);
	endtask
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk("total after reset", 32'(transfer_total_o), 32'h1);
		chk("pc after reset", instr_addr_o, 32'h0);
		t_load();
		t_store();
		t_bp();
		t_trap();
		t_spr();
		t_pc();
		wrap_up();
	end
endmodule
`default_nettype wire
